// ==== hw/host_port_map.svh ====
// Purpose: Constants for the parallel host register port
// Assumes: 250 MHz core clock
// Notes:   Times in ns and us, cycle counts derived from them
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH
`define CLK_PERIOD_NS      4
`define ASYNC_RDY_MAX_NS   65
`define ASYNC_RDY_CYC      (`ASYNC_RDY_MAX_NS / `CLK_PERIOD_NS)
`define SYNC_RDY_HCLKS     2
`define RESET_MIN_US       5
`define RESET_MIN_CYC      ((`RESET_MIN_US * 1000) / `CLK_PERIOD_NS)
`define ALARM_STATUS_ADDR  8'h03
`define ALARM_STATUS_RST   8'h00
`define CTRL_REG_RST       8'h00
`define NUM_REGS           256
`endif

// ==== hw/host_port_pkg.sv ====
// Purpose: Types for the parallel host register port
// Assumes: Constants come from host_port_map.svh
// Notes:   None
package host_port_pkg;
	typedef enum logic [1:0] {
		st_idle,
		st_wait,
		st_ready,
		st_done
	} port_state_t;
	typedef logic [7:0] byte_t;
endpackage

// ==== hw/host_reg_port.sv ====
// Purpose: Parallel host port reaching the on-chip registers
// Assumes: Pins are asynchronous to clk and pass two flops first
// Notes:   Reset pin is folded into the core reset with a minimum hold
`timescale 1ns/1ns
`include "host_port_map.svh"

// How it works
// R01 - Strap low selects asynchronous timing, high selects host clock timing.
// R02 - Synchronous mode times accesses from host clock; period at least 15 ns.
// R03 - Eight-bit direct address picks one register, no paging.
// R04 - Strobes are ignored unless unit select is low.
// R05 - Host sets address and select before any strobe.
// R06 - Read strobe falling with select low starts read, enables data drivers.
// R07 - Write strobe falling with select low starts write, data bus input.
// R08 - Host drives write data before lowering write strobe.
// R09 - Ready low marks the cycle complete and next command accepted.
// R10 - Ready on read means valid data; on write, data stored.
// R11 - Asynchronous mode: ready within 65 ns of the strobe.
// R12 - Synchronous mode: ready two host clock periods after the strobe.
// R13 - Host ends a read by raising read strobe after ready.
// R14 - Host raises select after each cycle before the next command.
// R15 - Interrupt low on alarm change, released once status is read.
// R16 - Both polled and interrupt-driven use are supported.
// R17 - Low reset input resets the device and its registers.
// R18 - Reset held at least 5 us; registers take defaults afterwards.
// R19 - Synchronous mode samples on host clock rises; ready held until strobe release.
module host_reg_port
	import host_port_pkg::*;
(
	input  wire logic       clk,        // Core clock 250 MHz
	input  wire logic       rst,        // Core reset
	input  wire logic       pmode,      // Timing strap
	input  wire logic       pclk,       // Host bus clock pin
	input  wire logic [7:0] addr,       // Address pins
	input  wire logic [7:0] d_in,       // Data pins in
	output logic      [7:0] d_out,      // Data pins out
	output logic            d_oe_n,     // Data drive enable, low drives
	input  wire logic       cs_n,       // Unit select
	input  wire logic       rd_n,       // Read strobe
	input  wire logic       wr_n,       // Write strobe
	output logic            rdy_n,      // Ready
	output logic            int_n,      // Interrupt
	input  wire logic       reset_n,    // Device reset pin
	input  wire logic [7:0] alarm_ev,   // Alarm change pulses
	output logic            in_reset    // Device held in reset
);
	// Two-flop synchronisers
	logic [12:0] s1_ff;
	logic [12:0] s2_ff;
	wire  [12:0] pin_vec = {pmode, pclk, reset_n, cs_n, rd_n, wr_n, addr[6:0]};
	logic        a7_s1_ff;
	logic        a7_s2_ff;
	byte_t       din_s1_ff;
	byte_t       din_s2_ff;

	always_ff @(posedge clk) begin
		s1_ff <= pin_vec;
		s2_ff <= s1_ff;
		a7_s1_ff <= addr[7];
		a7_s2_ff <= a7_s1_ff;
		din_s1_ff <= d_in;
		din_s2_ff <= din_s1_ff;
	end

	wire       pmode_s   = s2_ff[12];
	wire       pclk_s    = s2_ff[11];
	wire       reset_n_s = s2_ff[10];
	wire       cs_n_s    = s2_ff[9];
	wire       rd_n_s    = s2_ff[8];
	wire       wr_n_s    = s2_ff[7];
	wire [7:0] addr_s    = {a7_s2_ff, s2_ff[6:0]};

	// Reset pin stretch and hold
	logic [10:0] rst_cnt_ff;
	logic [10:0] nxt_rst_cnt;
	wire         rst_load = rst || !reset_n_s;                 // [R17] [R18]
	wire         rst_hold = (rst_cnt_ff != 11'h000);
	wire         dev_rst  = rst || rst_hold || !reset_n_s;

	// Any reset reloads the full hold, so a short pin pulse still lasts 5 us
	always_comb begin
		nxt_rst_cnt = rst_cnt_ff;
		if (rst_load)
			nxt_rst_cnt = 11'(`RESET_MIN_CYC);
		else if (rst_hold)
			nxt_rst_cnt = rst_cnt_ff - 11'h001;
	end

	always_ff @(posedge clk) begin
		rst_cnt_ff <= nxt_rst_cnt;
	end
	assign in_reset = dev_rst;

	// Strap captured after reset release
	logic sync_mode_ff;
	logic strap_done_ff;
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			sync_mode_ff  <= 1'b0;
			strap_done_ff <= 1'b0;
		end else if (!strap_done_ff) begin
			sync_mode_ff  <= pmode_s; // [R01]
			strap_done_ff <= 1'b1;
		end
	end

	// Host clock rising edge as an enable
	logic pclk_d_ff;
	always_ff @(posedge clk) begin
		pclk_d_ff <= pclk_s;
	end
	wire pclk_rise = pclk_s && !pclk_d_ff;
	wire sample_en = sync_mode_ff ? pclk_rise : 1'b1; // [R02] [R19]

	// Access detection
	wire rd_act = !cs_n_s && !rd_n_s; // [R04]
	wire wr_act = !cs_n_s && !wr_n_s; // [R04]
	wire strobe_act = rd_act || wr_act;

	// Alarm status lives in the register store
	logic alarm_pend;

	reg_access_if acc ();
	reg_store u_store (
		.clk        (clk),
		.rst        (dev_rst),
		.bus        (acc),
		.alarm_ev   (alarm_ev),
		.alarm_pend (alarm_pend)
	);

	// Transfer state
	port_state_t state_ff;
	port_state_t nxt_state;
	logic        is_read_ff;
	logic [1:0]  hclk_cnt_ff;
	byte_t       addr_ff;
	byte_t       wdata_ff;
	logic        rd_oe_ff;
	logic        rdy_n_ff;
	logic        int_n_ff;

	// State decodes
	wire in_idle  = (state_ff == st_idle);
	wire in_wait  = (state_ff == st_wait);
	wire in_ready = (state_ff == st_ready);
	wire in_done  = (state_ff == st_done);

	// Take, count and finish an access
	wire       start     = in_idle && sample_en && strobe_act;
	wire       hclk_ok   = !sync_mode_ff || (hclk_cnt_ff == 2'(`SYNC_RDY_HCLKS - 1)); // [R12]
	wire       go_ready  = in_wait && sample_en && hclk_ok;
	wire       released  = sample_en && !strobe_act;
	wire       hclk_tick = in_wait && pclk_rise;
	wire [1:0] hclk_inc  = hclk_cnt_ff + 2'h1;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			st_idle:  if (start) nxt_state = st_wait;
			st_wait:  if (go_ready) nxt_state = st_ready;
			st_ready: nxt_state = st_done;
			st_done:  if (released) nxt_state = st_idle; // [R19]
		endcase
	end

	// Access fields held from the taking edge; write data is sampled there too
	wire        nxt_is_read  = start ? rd_act : is_read_ff;
	wire byte_t nxt_addr     = start ? addr_s : addr_ff;                    // [R03]
	wire byte_t nxt_wdata    = start ? din_s2_ff : wdata_ff;                // [R07]
	wire [1:0]  nxt_hclk_cnt = start ? 2'h0 : (hclk_tick ? hclk_inc : hclk_cnt_ff);

	// Pin-side outputs
	wire rd_busy    = !in_idle || start;
	wire rd_ending  = released && in_done;
	wire nxt_rd_oe  = rd_act && rd_busy && !rd_ending;                      // [R06]
	wire ready_hold = in_done && !released;
	wire nxt_rdy_n  = !(in_ready || ready_hold);                            // [R09] [R11]
	wire nxt_int_n  = !alarm_pend;                                          // [R15] [R16]

	// Core transfer registers
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			state_ff    <= st_idle;
			is_read_ff  <= 1'b0;
			hclk_cnt_ff <= 2'h0;
			addr_ff     <= 8'h00;
			wdata_ff    <= 8'h00;
		end else begin
			state_ff    <= nxt_state;
			is_read_ff  <= nxt_is_read;
			hclk_cnt_ff <= nxt_hclk_cnt;
			addr_ff     <= nxt_addr;
			wdata_ff    <= nxt_wdata;
		end
	end

	// Output flops; ready drops only after the release is seen
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			rd_oe_ff <= 1'b0;
			rdy_n_ff <= 1'b1;
			int_n_ff <= 1'b1;
		end else begin
			rd_oe_ff <= nxt_rd_oe;
			rdy_n_ff <= nxt_rdy_n;
			int_n_ff <= nxt_int_n;
		end
	end

	// Register store access strobes
	assign acc.addr   = addr_ff;                                  // [R03]
	assign acc.wdata  = wdata_ff;
	assign acc.wr_stb = go_ready && !is_read_ff;                  // [R07] [R10]
	assign acc.rd_stb = go_ready && is_read_ff;                   // [R06]

	// Pins
	assign rdy_n  = rdy_n_ff;
	assign int_n  = int_n_ff;
	assign d_out  = acc.rdata; // [R10]
	assign d_oe_n = !rd_oe_ff;
endmodule

// ==== hw/reg_access_if.sv ====
// Purpose: Register access carrier between port control and register file
// Assumes: One clock
// Notes:   Write and read are one-cycle strobes
`timescale 1ns/1ns
interface reg_access_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       wr_stb;
	logic       rd_stb;
	modport ctrl (output addr, output wdata, output wr_stb, output rd_stb, input rdata);
	modport regs (input addr, input wdata, input wr_stb, input rd_stb, output rdata);
endinterface

// ==== hw/reg_store.sv ====
// Purpose: Register array behind the host port
// Assumes: Reset is synchronous active high
// Notes:   Alarm status is sticky, cleared by a read; the set wins
`timescale 1ns/1ns
`include "host_port_map.svh"
module reg_store
	import host_port_pkg::*;
(
	input  wire logic clk,          // Core clock
	input  wire logic rst,          // Reset
	reg_access_if.regs bus,         // Access strobes
	input  wire logic [7:0] alarm_ev, // Alarm change pulses
	output logic      alarm_pend    // Any alarm pending
);
	byte_t mem_ff [`NUM_REGS];
	byte_t rdata_ff;
	byte_t alarm_ff;
	wire   is_alarm = (bus.addr == `ALARM_STATUS_ADDR);
	wire   clr_alarm = bus.rd_stb && is_alarm;
	wire   byte_t nxt_alarm = (clr_alarm ? 8'h00 : alarm_ff) | alarm_ev; // [R15]

	assign bus.rdata = rdata_ff;
	assign alarm_pend = |alarm_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			alarm_ff <= `ALARM_STATUS_RST; // [R17]
			rdata_ff <= 8'h00;
		end else begin
			alarm_ff <= nxt_alarm;
			if (bus.rd_stb)
				rdata_ff <= is_alarm ? alarm_ff : mem_ff[bus.addr];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < `NUM_REGS; i++)
				mem_ff[i] <= `CTRL_REG_RST; // [R18]
		end else if (bus.wr_stb) begin
			mem_ff[bus.addr] <= bus.wdata; // [R10]
		end
	end
endmodule

// ==== sim/host_cpu.sv ====
// Purpose: Local processor driving the host port
// Assumes: Changes pins at falling clk edges
// Notes:   Released data bus shows inverse of last byte
`timescale 1ns/1ns
module host_cpu
	import host_port_pkg::*;
(
	input  wire logic  clk,    // clock
	input  wire byte_t d_out,  // device data
	input  wire logic  d_oe_n, // device drive
	input  wire logic  rdy_n,  // ready
	output logic       pclk,   // bus clock
	output logic       cs_n,   // select
	output logic       rd_n,   // read
	output logic       wr_n,   // write
	output byte_t      addr,   // address
	output byte_t      d_in    // bus level
);
	byte_t wdat;
	logic  drv;
	assign d_in = !d_oe_n ? d_out : (drv ? wdat : ~wdat);
	initial begin
		pclk = 1'b0;
		forever #8 pclk = ~pclk;
	end
	initial begin
		{cs_n, rd_n, wr_n, drv} = 4'he;
		addr = 8'h00;
		wdat = 8'h00;
	end
	task automatic access(input logic wr, input logic sel, input byte_t a,
		input byte_t wd, output byte_t rd, output logic ok);
		int i;
		@(negedge clk);
		addr = a;
		cs_n = !sel;
		wdat = wd;
		drv = wr;
		@(negedge clk);
		if (wr) begin
			wr_n = 1'b0;
		end else begin
			rd_n = 1'b0;
		end
		for (i = 0; i < 40 && rdy_n !== 1'b0; i++) @(negedge clk);
		ok = (rdy_n === 1'b0);
		rd = d_out;
		@(negedge clk);
		{cs_n, rd_n, wr_n, drv} = 4'he;
		repeat (8) @(negedge clk);
	endtask
endmodule

// ==== sim/host_port_checker.sv ====
// Purpose: Pin-level checks of the host port
// Assumes: One access at a time, pclk period 16 ns
// Notes:   Bounds in 4 ns cycles
`timescale 1ns/1ns
module host_port_checker (
	input wire logic       clk,      // clock
	input wire logic       rst,      // reset
	input wire logic       pmode,    // strap
	input wire logic       d_oe_n,   // drive enable
	input wire logic       cs_n,     // select
	input wire logic       rd_n,     // read
	input wire logic       wr_n,     // write
	input wire logic       rdy_n,    // ready
	input wire logic       int_n,    // interrupt
	input wire logic [7:0] alarm_ev, // alarms
	input wire logic       in_reset  // in reset
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	hold_rst_a: assert property ($fell(rst) |-> in_reset[*8])
		else $error("reset hold short");
	rst_quiet_a: assert property (in_reset |-> rdy_n && int_n && d_oe_n)
		else $error("outputs active in reset");
	desel_idle_a: assert property (cs_n[*8] |-> rdy_n && d_oe_n)
		else $error("active while deselected");
	no_rd_drive_a: assert property (rd_n[*8] |-> d_oe_n)
		else $error("drives without read");
	async_read_a: assert property (!pmode && !cs_n && $fell(rd_n) |-> ##[1:16] (!rdy_n && !d_oe_n))
		else $error("async read late");
	async_write_a: assert property (!pmode && !cs_n && $fell(wr_n) |-> ##[1:16] !rdy_n)
		else $error("async write late");
	sync_early_a: assert property (pmode && !cs_n && $fell(rd_n && wr_n) |-> rdy_n[*8])
		else $error("sync ready early");
	sync_late_a: assert property (pmode && !cs_n && $fell(rd_n && wr_n) |-> ##[8:30] !rdy_n)
		else $error("sync ready late");
	ready_hold_a: assert property (!rdy_n && !cs_n && !(rd_n && wr_n) |=> !rdy_n)
		else $error("ready dropped");
	alarm_int_a: assert property (!in_reset && alarm_ev != 8'h00 |-> ##[1:4] !int_n)
		else $error("no interrupt");
	cover property (!rdy_n && !rd_n);
	cover property (!rdy_n && !wr_n);
	cover property (!int_n);
endmodule

// ==== sim/lin_iface_host_register_port_tb.sv ====
// Purpose: Self-checking bench of the host port
// Assumes: Inputs change at falling edges
// Notes:   Strap changed only under reset
`timescale 1ns/1ns
`include "host_port_map.svh"
module lin_iface_host_register_port_tb
	import host_port_pkg::*;
();
	logic clk, rst, pmode, reset_n, pclk, d_oe_n, cs_n, rd_n, wr_n, rdy_n, int_n, in_reset, ok;
	byte_t alarm_ev, addr, d_in, d_out, q;
	int    n_mismatch, samples_checked, cyc;
	host_reg_port u_host_reg_port (.clk(clk), .rst(rst), .pmode(pmode), .pclk(pclk),
		.addr(addr), .d_in(d_in), .d_out(d_out), .d_oe_n(d_oe_n), .cs_n(cs_n),
		.rd_n(rd_n), .wr_n(wr_n), .rdy_n(rdy_n), .int_n(int_n), .reset_n(reset_n),
		.alarm_ev(alarm_ev), .in_reset(in_reset));
	host_cpu u_host_cpu (.clk(clk), .d_out(d_out), .d_oe_n(d_oe_n), .rdy_n(rdy_n),
		.pclk(pclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .d_in(d_in));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	task automatic put(input byte_t a, input byte_t d);
		u_host_cpu.access(1'b1, 1'b1, a, d, q, ok);
		check("write ready", 8'h01, {7'h00, ok});
	endtask
	task automatic get(input byte_t a, input byte_t exp);
		u_host_cpu.access(1'b0, 1'b1, a, 8'h00, q, ok);
		check("read ready", 8'h01, {7'h00, ok});
		check("read data", exp, q);
	endtask
	task automatic boot();
		int i;
		for (i = 0; i < 1400 && in_reset !== 1'b0; i++) @(negedge clk);
		check("in reset", 8'h00, {7'h00, in_reset});
		@(negedge clk);
	endtask
	task automatic t_rw();
		put(8'h00, 8'ha5);
		put(8'hff, 8'h3c);
		get(8'h00, 8'ha5);
		get(8'hff, 8'h3c);
		get(8'h7e, 8'h00);
	endtask
	task automatic t_nosel();
		u_host_cpu.access(1'b1, 1'b0, 8'h20, 8'h77, q, ok);
		check("deselected ready", 8'h00, {7'h00, ok});
		get(8'h20, 8'h00);
	endtask
	task automatic t_alarm();
		alarm_ev = 8'h04;
		@(negedge clk);
		alarm_ev = 8'h00;
		repeat (4) @(negedge clk);
		check("interrupt", 8'h00, {7'h00, int_n});
		get(`ALARM_STATUS_ADDR, 8'h04);
		check("interrupt", 8'h01, {7'h00, int_n});
		get(`ALARM_STATUS_ADDR, 8'h00);
	endtask
	task automatic t_pin_reset();
		put(8'h10, 8'h5a);
		get(8'h10, 8'h5a);
		reset_n = 1'b0;
		repeat (4) @(negedge clk);
		check("in reset", 8'h01, {7'h00, in_reset});
		reset_n = 1'b1;
		boot();
		get(8'h10, 8'h00);
	endtask
	task automatic t_sync();
		pmode = 1'b1;
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		boot();
		put(8'h40, 8'hc3);
		get(8'h40, 8'hc3);
	endtask
	initial begin
		{rst, pmode, reset_n, cyc, n_mismatch, samples_checked} = {3'b101, 96'h0};
		alarm_ev = 8'h00;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		boot();
		t_rw();
		t_nosel();
		t_alarm();
		t_pin_reset();
		t_sync();
		tally_and_finish();
	end
endmodule
bind host_reg_port host_port_checker u_host_port_checker (.clk(clk), .rst(rst),
	.pmode(pmode), .d_oe_n(d_oe_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
	.rdy_n(rdy_n), .int_n(int_n), .alarm_ev(alarm_ev), .in_reset(in_reset));
